//--- test/bls_flash_model.sv
/*
  Serial boot flash model holding one image of twelve bytes.
  Assumes mode 0 framing driven by the sequencer under test.
*/
`timescale 1ns/1ns
`default_nettype none
module bls_flash_model (
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // image with byte 0 lowest, and the command seen
  input wire logic [95:0] img,
  output logic [31:0] cmd
);
  int n = 0;
  initial spi_miso = 1'b0;
  always @(negedge spi_ss_n) begin
    n = 0;
    cmd = '0;
  end
  always @(posedge spi_sclk) begin
    if (!spi_ss_n && n < 32)
      cmd = {cmd[30:0], spi_mosi};
    n = n + 1;
  end
  // a released line flips so that a stale bit is never trusted
  always @(negedge spi_sclk or posedge spi_ss_n)
    if (spi_ss_n)
      spi_miso = ~spi_miso;
    else if (n >= 32 && n < 128)
      spi_miso = img[n - 32];
endmodule
`default_nettype wire

//--- test/test_bls_boot_seq.sv
/*
  Self-checking bench of the boot sequencer: straps, link, OTP, flash.
  Assumes the flash model and a 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_bls_boot_seq;
  int num_errors = 0, checks = 0, seed = 49, t, ns = 0;
  time tl = 0;
  logic clk = 0, nrst = 1, pll_ratio_strap_lo = 0, pll_ratio_strap_hi = 0;
  logic spi_miso, link_rx_valid = 0, link_tx_ready = 0, otp_rvalid = 0;
  logic ram_ready = 0, gpio_hiz, pull_en, spi_sclk, spi_ss_n, spi_mosi;
  logic link_b_pd_en, link_rx_ready, link_tx_valid, chan0_alloc, otp_rd;
  logic ram_we, wait_test, boot_fail, run, op = 0;
  logic [1:0] boot_src_strap = 0, link_b_wires_out, link_b_wires_oe_n;
  logic [31:0] security_word = 0, link_tx_chan, otp_rdata = 0, fcmd;
  logic [31:0] om[16];
  logic [95:0] fimg = '0;
  bls_pkg::bls_pll_t pll_cfg;
  bls_pkg::bls_tok_t link_rx_tok = '0, link_tx_tok;
  logic [12:0] tile_clk_num;
  logic [10:0] tile_clk_den, otp_addr, oa = '0;
  logic [15:0] ram_addr, run_addr;
  logic [7:0] ram_wdata;
  logic [7:0] q[$];
  logic [23:0] rq[$];
  logic [40:0] tq[$];
  bls_boot_seq dut (.*);
  bls_flash_model flash (.spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso,
    .img(fimg), .cmd(fcmd));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (ram_we && ram_ready) rq.push_back({ram_addr, ram_wdata});
    if (link_tx_valid && link_tx_ready)
      tq.push_back({link_tx_chan, link_tx_tok});
    if (otp_rd) begin
      op = 1;
      oa = otp_addr;
    end
  end
  // random stalls on the memory and ack sides
  always @(negedge clk) begin
    ram_ready <= 1'($random(seed));
    link_tx_ready <= 1'($random(seed));
    otp_rvalid <= op;
    otp_rdata <= om[oa[3:0]];
    op = 0;
  end
  always @(posedge spi_sclk) begin
    if (ns == 1) chk(41'(($time - tl) / 100), 160);
    tl = $time;
    ns++;
  end
  task chk(input logic [40:0] seen, input logic [40:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c = 32'hFFFFFFFF;
    foreach (b[i]) begin
      c ^= 32'(b[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  // mode 0 good check word, 1 corrupted, 2 skip value
  task mk(input int s, input int mode);
    logic [31:0] c;
    q = {};
    for (int i = 0; i < 4; i++) q.push_back(8'(s >> 8 * i));
    repeat (4 * s) q.push_back(8'($random(seed)));
    c = mode == 2 ? 32'h0D15AB1E : crc32(q) ^ 32'(mode);
    for (int i = 0; i < 4; i++)
      q.push_back(c[8 * i +: 8]);
  endtask
  task boot(input logic [1:0] ps, input logic [1:0] src, input logic sec);
    int od, f;
    nrst = 0;
    {pll_ratio_strap_hi, pll_ratio_strap_lo} = ps;
    boot_src_strap = src;
    security_word = $random(seed) & ~32'h20 | 32'(sec) << 5;
    repeat (2) @(negedge clk);
    chk(gpio_hiz, 1);
    nrst = 1;
    rq = {};
    tq = {};
    repeat (140) @(negedge clk);
    chk({gpio_hiz, pull_en}, 2'b10);
    repeat (15) @(negedge clk);
    chk({gpio_hiz, pull_en}, 2'b01);
    od = ps == 0 ? 1 : 2;
    f = ps == 0 ? 122 : ps == 1 ? 23 : ps == 2 ? 49 : 119;
    chk(pll_cfg, {3'(od), 12'(f), 6'h00});
    chk(tile_clk_num, f + 1);
    chk(tile_clk_den, 2 * od + 2);
  endtask
  task done(input int s, input logic ok);
    t = 0;
    while (run !== 1'b1 && boot_fail !== 1'b1 && t < 40000) begin
      @(negedge clk);
      t++;
    end
    repeat (3) @(negedge clk);
    chk({run, boot_fail}, {ok, !ok});
    chk(run_addr, 16'h0);
    if (ok) begin
      chk(rq.size(), 4 * s);
      foreach (rq[i]) chk(rq[i], {16'(i), q[4 + i]});
    end
    $display("test finished at %0t, mismatches %0d", $time, num_errors);
  endtask
  task send(input logic c, input logic [7:0] d);
    link_rx_valid = 1;
    link_rx_tok = '{c, d};
    t = 0;
    while (link_rx_ready !== 1'b1 && t < 200) begin
      @(negedge clk);
      t++;
    end
    chk(link_rx_ready, 1);
    @(negedge clk);
  endtask
  task link(input logic [31:0] ack, input int s, input int mode);
    mk(s, mode);
    boot(2'h2, 2'h2, 0);
    repeat (3) @(negedge clk);
    chk({link_b_wires_oe_n, link_b_wires_out}, 4'h0);
    chk({link_b_pd_en, chan0_alloc}, 2'b01);
    for (int i = 0; i < 4; i++) send(0, ack[8 * i +: 8]);
    foreach (q[i]) send(0, q[i]);
    send(1, 8'h01);
    link_rx_valid = 0;
    done(s, mode != 1);
    if (mode != 1) begin
      chk(tq.size(), ack != 32'h0000FF02);
      if (tq.size() > 0) chk(tq[0], {ack, 1'b1, 8'h01});
      chk(chan0_alloc, 0);
    end
  endtask
  initial begin
    boot(2'h0, 2'h0, 0);
    chk(wait_test, 1);
    $display("test finished at %0t, mismatches %0d", $time, num_errors);
    boot(2'h1, 2'h1, 0);
    chk(boot_fail, 1);
    $display("test finished at %0t, mismatches %0d", $time, num_errors);
    link($random(seed), 3, 0);
    link(32'h0000FF02, 1, 2);
    link($random(seed), 2, 1);
    mk(2, 2);
    for (int i = 0; i < 4; i++) om[i] = {q[4*i+3], q[4*i+2], q[4*i+1], q[4*i]};
    boot(2'h0, 2'h3, 1);
    chk(spi_ss_n, 1);
    done(2, 1);
    mk(1, 0);
    foreach (q[i]) fimg[8 * i +: 8] = q[i];
    boot(2'h3, 2'h3, 0);
    done(1, 1);
    chk(fcmd, 32'h03000000);
    chk({spi_ss_n, spi_sclk}, 2'b10);
    print_verdict;
  end
  initial begin
    // the flash boot dominates at about 21k cycles; the 40k-cycle limit is under twice the total
    #4_000_000;
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire

//--- verilog/bls_boot_seq.sv
/*
  Reset-release and boot sequencer: strap decode, image fetch from
  serial flash, link B or OTP, checksum and load into RAM.
  Assumes synchronous pins, a RAM that may stall with ram_ready, and a
  link token layer that already turns wires into byte tokens.
*/
`timescale 1ns/1ns
`default_nettype none
// Operation
// - pins stay high impedance while system reset is low
// - internal reset phase, then pull resistors on, then boot
// - boot straps: 00 wait test port, 01 reserved, 10 link, 11 flash
// - secure boot bit forces OTP boot and ignores boot straps
// - image: word count, four bytes per word, CRC or magic skip
// - count and CRC fields are little-endian
// - program bytes go from lowest RAM address; run starts there
// - checksum covers count field and program, not CRC field
// - reflected CRC-32, preset all ones, result inverted
// - flash boot as master, clock at core rate over 160
// - one READ command with 24-bit address zero, then stream
// - serial clock idles low, sampled on rising edge
// - each image byte arrives least significant bit first
// - link enabled after 200 ns, pulldowns off, outputs low
// - take channel end 0, read ack channel, image, END token
// - send END to ack channel unless it is 0000FF02, free channel end 0, run
// - secure boot reads image from OTP word address 0
// - PLL ratio straps select divider, feedback, input divider
// - tile clock is osc times (F+1)/2/(R+1)/(OD+1)
module bls_boot_seq (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // straps and security word
  input wire logic pll_ratio_strap_lo,
  input wire logic pll_ratio_strap_hi,
  input wire logic [1:0] boot_src_strap,
  input wire logic [31:0] security_word,
  // pad and clock control
  output logic gpio_hiz,
  output logic pull_en,
  output bls_pkg::bls_pll_t pll_cfg,
  output logic [12:0] tile_clk_num,
  output logic [10:0] tile_clk_den,
  // serial flash
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  // link b
  output logic [1:0] link_b_wires_out,
  output logic [1:0] link_b_wires_oe_n,
  output logic link_b_pd_en,
  input wire logic link_rx_valid,
  input wire bls_pkg::bls_tok_t link_rx_tok,
  output logic link_rx_ready,
  output logic link_tx_valid,
  output bls_pkg::bls_tok_t link_tx_tok,
  output logic [31:0] link_tx_chan,
  input wire logic link_tx_ready,
  output logic chan0_alloc,
  // otp
  output logic otp_rd,
  output logic [10:0] otp_addr,
  input wire logic otp_rvalid,
  input wire logic [31:0] otp_rdata,
  // ram
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [7:0] ram_wdata,
  input wire logic ram_ready,
  // status
  output logic wait_test,
  output logic boot_fail,
  output logic run,
  output logic [15:0] run_addr
);
  bls_pkg::bls_state_t st_r;
  bls_pkg::bls_pstage_t ps_r;
  logic [7:0] cnt_r;
  logic [31:0] crc_r, asm_r, words_r, ack_chan_r;
  logic [1:0] idx_r;
  logic crc_ok_r;
  logic [6:0] div_cnt_r;
  logic [31:0] spi_sh_r;
  logic [5:0] spi_bits_r;
  logic [2:0] rx_cnt_r;
  logic [7:0] rx_byte_r;
  logic spi_cmd_r, spi_tick, spi_push;
  logic [31:0] otp_word_r;
  logic otp_have_r, otp_wait_r, otp_push;
  logic [1:0] otp_idx_r;
  logic link_push, want, take, stall;
  logic buf_in_valid, buf_in_ready, buf_out_valid;
  bls_pkg::bls_tok_t buf_in, buf_out;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] x;
    x = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ bls_pkg::CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // main sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= bls_pkg::S_RESET;
      cnt_r <= 8'h00;
    end else begin
      unique case (st_r)
        bls_pkg::S_RESET: begin
          if (cnt_r == bls_pkg::RST_PHASE_CYC - 8'h01) begin
            st_r <= bls_pkg::S_DECODE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        bls_pkg::S_DECODE: begin
          cnt_r <= 8'h00;
          if (security_word[bls_pkg::SEC_BOOT_BIT]) begin
            st_r <= bls_pkg::S_OTP;
          end else begin
            unique case (boot_src_strap)
              bls_pkg::SRC_NONE: st_r <= bls_pkg::S_WAIT_TEST;
              bls_pkg::SRC_RSVD: st_r <= bls_pkg::S_FAIL;
              bls_pkg::SRC_LINK: st_r <= bls_pkg::S_LINK_EN;
              bls_pkg::SRC_SPI: st_r <= bls_pkg::S_SPI;
            endcase
          end
        end
        bls_pkg::S_LINK_EN: begin
          if (cnt_r == bls_pkg::LINK_EN_CYC - 8'h01) begin
            st_r <= bls_pkg::S_LINK;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        bls_pkg::S_LINK, bls_pkg::S_SPI, bls_pkg::S_OTP: begin
          if (ps_r == bls_pkg::P_DONE) begin
            if (!crc_ok_r) begin
              st_r <= bls_pkg::S_FAIL;
            end else if (st_r == bls_pkg::S_LINK &&
                         ack_chan_r != bls_pkg::NULL_CHAN) begin
              st_r <= bls_pkg::S_ACK;
            end else begin
              st_r <= bls_pkg::S_RUN;
            end
          end
        end
        bls_pkg::S_ACK: begin
          if (link_tx_valid && link_tx_ready) begin
            st_r <= bls_pkg::S_RUN;
          end
        end
        bls_pkg::S_WAIT_TEST, bls_pkg::S_RUN, bls_pkg::S_FAIL: begin
        end
        default: st_r <= bls_pkg::S_FAIL;
      endcase
    end
  end

  // pads, clock settings and status
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gpio_hiz <= 1'b1;
      pull_en <= 1'b0;
      link_b_pd_en <= 1'b0;
      link_b_wires_out <= 2'h0;
      link_b_wires_oe_n <= 2'h3;
      pll_cfg <= bls_pkg::PLL_R00;
      tile_clk_num <= 13'h0000;
      tile_clk_den <= 11'h000;
      wait_test <= 1'b0;
      boot_fail <= 1'b0;
      run <= 1'b0;
      run_addr <= bls_pkg::RAM_BASE;
      chan0_alloc <= 1'b0;
    end else begin
      if (st_r == bls_pkg::S_DECODE) begin
        gpio_hiz <= 1'b0;
        pull_en <= 1'b1;
        link_b_pd_en <= 1'b1;
        // straps are static by now, so one sample is enough
        unique case ({pll_ratio_strap_hi, pll_ratio_strap_lo})
          2'h0: pll_cfg <= bls_pkg::PLL_R00;
          2'h1: pll_cfg <= bls_pkg::PLL_R01;
          2'h2: pll_cfg <= bls_pkg::PLL_R10;
          2'h3: pll_cfg <= bls_pkg::PLL_R11;
        endcase
      end
      tile_clk_num <= {1'b0, pll_cfg.feedback} + 13'h0001;
      tile_clk_den <= 11'({5'h00, pll_cfg.input_div} + 11'h001) *
                      11'({8'h00, pll_cfg.post_vco_divider} + 11'h001) *
                      11'h002;
      if (st_r == bls_pkg::S_LINK) begin
        link_b_pd_en <= 1'b0;
        link_b_wires_oe_n <= 2'h0;
      end
      chan0_alloc <= st_r == bls_pkg::S_LINK || st_r == bls_pkg::S_ACK;
      wait_test <= st_r == bls_pkg::S_WAIT_TEST;
      boot_fail <= st_r == bls_pkg::S_FAIL;
      run <= st_r == bls_pkg::S_RUN;
    end
  end

  // acknowledge token to the channel named first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_tx_valid <= 1'b0;
      link_tx_tok <= '0;
      link_tx_chan <= 32'h00000000;
    end else begin
      link_tx_valid <= st_r == bls_pkg::S_ACK &&
                       !(link_tx_valid && link_tx_ready);
      link_tx_tok <= '{1'b1, bls_pkg::END_TOKEN};
      link_tx_chan <= ack_chan_r;
    end
  end

  // flash and OTP sources stop once the checksum field is in
  assign want = ps_r != bls_pkg::P_END && ps_r != bls_pkg::P_DONE;

  // link receive: one token per two cycles keeps ready a plain flop
  assign link_push = link_rx_valid && link_rx_ready;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link_rx_ready <= 1'b0;
    end else begin
      link_rx_ready <= st_r == bls_pkg::S_LINK && buf_in_ready &&
                       ps_r != bls_pkg::P_DONE && !link_push;
    end
  end

  // serial flash master, mode 0
  assign spi_tick = st_r == bls_pkg::S_SPI && !spi_ss_n &&
                    div_cnt_r == bls_pkg::SPI_HALF_CYC - 7'h01;
  assign spi_push = spi_tick && !spi_sclk && !spi_cmd_r &&
                    rx_cnt_r == 3'h7 && buf_in_ready && want;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      spi_ss_n <= 1'b1;
      spi_sclk <= 1'b0;
      spi_mosi <= 1'b0;
      spi_sh_r <= 32'h00000000;
      spi_bits_r <= 6'h00;
      spi_cmd_r <= 1'b0;
      rx_cnt_r <= 3'h0;
      rx_byte_r <= 8'h00;
      div_cnt_r <= 7'h00;
    end else if (st_r != bls_pkg::S_SPI || !want || spi_ss_n) begin
      // a frame opens here and closes only once the clock is back low
      spi_sclk <= 1'b0;
      div_cnt_r <= 7'h00;
      if (!spi_sclk && st_r == bls_pkg::S_SPI && spi_ss_n && want) begin
        spi_ss_n <= 1'b0;
        spi_sh_r <= {bls_pkg::SPI_READ_CMD, bls_pkg::SPI_START_ADDR};
        spi_mosi <= bls_pkg::SPI_READ_CMD[7];
        spi_cmd_r <= 1'b1;
        spi_bits_r <= 6'h00;
      end else if (!spi_sclk) begin
        spi_ss_n <= 1'b1;
      end
    end else if (spi_tick) begin
      div_cnt_r <= 7'h00;
      if (!spi_sclk) begin
        // a full byte with no room holds the clock low until room frees
        if (spi_cmd_r || rx_cnt_r != 3'h7 || buf_in_ready) begin
          spi_sclk <= 1'b1;
          if (spi_cmd_r) begin
            spi_bits_r <= spi_bits_r + 6'h01;
          end else begin
            rx_byte_r <= {spi_miso, rx_byte_r[7:1]};
            rx_cnt_r <= rx_cnt_r + 3'h1;
          end
        end
      end else begin
        spi_sclk <= 1'b0;
        if (spi_bits_r == bls_pkg::SPI_CMD_BITS) begin
          spi_cmd_r <= 1'b0;
        end
        spi_mosi <= spi_sh_r[30];
        spi_sh_r <= {spi_sh_r[30:0], 1'b0};
      end
    end else begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  // otp reader, words split low byte first
  assign otp_push = st_r == bls_pkg::S_OTP && otp_have_r &&
                    buf_in_ready && want;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      otp_rd <= 1'b0;
      otp_addr <= bls_pkg::OTP_BASE;
      otp_word_r <= 32'h00000000;
      otp_have_r <= 1'b0;
      otp_wait_r <= 1'b0;
      otp_idx_r <= 2'h0;
    end else begin
      otp_rd <= 1'b0;
      if (st_r == bls_pkg::S_OTP && want && !otp_have_r &&
          !otp_wait_r && !otp_rd) begin
        otp_rd <= 1'b1;
        otp_wait_r <= 1'b1;
      end
      if (otp_wait_r && otp_rvalid) begin
        otp_word_r <= otp_rdata;
        otp_have_r <= 1'b1;
        otp_wait_r <= 1'b0;
        otp_addr <= otp_addr + 11'h001;
      end
      if (otp_push) begin
        otp_word_r <= {8'h00, otp_word_r[31:8]};
        otp_idx_r <= otp_idx_r + 2'h1;
        if (otp_idx_r == 2'h3) begin
          otp_have_r <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    buf_in_valid = 1'b0;
    buf_in = '0;
    if (link_push) begin
      buf_in_valid = 1'b1;
      buf_in = link_rx_tok;
    end else if (spi_push) begin
      buf_in_valid = 1'b1;
      buf_in = '{1'b0, {spi_miso, rx_byte_r[7:1]}};
    end else if (otp_push) begin
      buf_in_valid = 1'b1;
      buf_in = '{1'b0, otp_word_r[7:0]};
    end
  end

  bls_buf2 u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_data(buf_in),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out),
    .out_ready(take)
  );

  // image parser and RAM writer
  assign stall = ram_we && !ram_ready;
  assign take = buf_out_valid && !stall && ps_r != bls_pkg::P_DONE &&
                (st_r == bls_pkg::S_LINK || st_r == bls_pkg::S_SPI ||
                 st_r == bls_pkg::S_OTP);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ps_r <= bls_pkg::P_SIZE;
      crc_r <= bls_pkg::CRC_INIT;
      asm_r <= 32'h00000000;
      words_r <= 32'h00000000;
      ack_chan_r <= bls_pkg::NULL_CHAN;
      idx_r <= 2'h0;
      crc_ok_r <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= bls_pkg::RAM_BASE;
      ram_wdata <= 8'h00;
    end else if (st_r == bls_pkg::S_DECODE) begin
      crc_r <= bls_pkg::CRC_INIT;
      ps_r <= (boot_src_strap == bls_pkg::SRC_LINK &&
               !security_word[bls_pkg::SEC_BOOT_BIT]) ?
              bls_pkg::P_ACK : bls_pkg::P_SIZE;
      idx_r <= 2'h0;
      ram_addr <= bls_pkg::RAM_BASE;
    end else begin
      if (ram_we && ram_ready) begin
        ram_we <= 1'b0;
        ram_addr <= ram_addr + 16'h0001;
      end
      if (take) begin
        asm_r <= {buf_out.data, asm_r[31:8]};
        if (ps_r != bls_pkg::P_END && !buf_out.ctrl) begin
          idx_r <= idx_r + 2'h1;
        end
        unique case (ps_r)
          bls_pkg::P_ACK: begin
            if (idx_r == 2'h3) begin
              ack_chan_r <= {buf_out.data, asm_r[31:8]};
              ps_r <= bls_pkg::P_SIZE;
            end
          end
          bls_pkg::P_SIZE: begin
            crc_r <= crc_byte(crc_r, buf_out.data);
            if (idx_r == 2'h3) begin
              words_r <= {buf_out.data, asm_r[31:8]};
              ps_r <= ({buf_out.data, asm_r[31:8]} == 32'h00000000) ?
                      bls_pkg::P_CRC : bls_pkg::P_PROG;
            end
          end
          bls_pkg::P_PROG: begin
            crc_r <= crc_byte(crc_r, buf_out.data);
            ram_we <= 1'b1;
            ram_wdata <= buf_out.data;
            if (idx_r == 2'h3) begin
              words_r <= words_r - 32'h00000001;
              if (words_r == 32'h00000001) begin
                ps_r <= bls_pkg::P_CRC;
              end
            end
          end
          bls_pkg::P_CRC: begin
            if (idx_r == 2'h3) begin
              crc_ok_r <= {buf_out.data, asm_r[31:8]} == bls_pkg::CRC_SKIP ||
                          {buf_out.data, asm_r[31:8]} == ~crc_r;
              ps_r <= (st_r == bls_pkg::S_LINK) ?
                      bls_pkg::P_END : bls_pkg::P_DONE;
            end
          end
          bls_pkg::P_END: begin
            if (buf_out.ctrl && buf_out.data == bls_pkg::END_TOKEN) begin
              ps_r <= bls_pkg::P_DONE;
            end
          end
          bls_pkg::P_DONE: begin
          end
          default: ps_r <= bls_pkg::P_DONE;
        endcase
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_hiz_in_reset: assert property (
    st_r == bls_pkg::S_RESET |-> gpio_hiz && !pull_en)
    else $error("pins left high impedance state during reset phase");
  chk_reset_phase_len: assert property (
    $fell(gpio_hiz) |-> $past(cnt_r) == bls_pkg::RST_PHASE_CYC - 8'h01)
    else $error("internal reset phase has wrong length");
  chk_src_flash: assert property (
    st_r == bls_pkg::S_DECODE && !security_word[bls_pkg::SEC_BOOT_BIT] &&
    boot_src_strap == bls_pkg::SRC_SPI |=> st_r == bls_pkg::S_SPI)
    else $error("flash strap did not start flash boot");
  chk_secure_otp: assert property (
    st_r == bls_pkg::S_DECODE && security_word[bls_pkg::SEC_BOOT_BIT]
    |=> st_r == bls_pkg::S_OTP ##1 otp_rd && otp_addr == bls_pkg::OTP_BASE)
    else $error("secure boot did not read OTP from address zero");
  chk_run_needs_crc: assert property (
    $rose(run) |-> crc_ok_r && run_addr == bls_pkg::RAM_BASE)
    else $error("ran code without a good checksum");
  chk_sclk_half: assert property (
    $rose(spi_sclk) |-> $past(div_cnt_r) == bls_pkg::SPI_HALF_CYC - 7'h01)
    else $error("serial clock half period wrong");
  chk_sclk_idle_low: assert property (
    spi_ss_n |-> !spi_sclk)
    else $error("serial clock high while deselected");
  chk_link_enable: assert property (
    $fell(link_b_pd_en) |-> link_b_wires_oe_n == 2'h0 &&
    link_b_wires_out == 2'h0 && $past(st_r, 2) == bls_pkg::S_LINK_EN)
    else $error("link enable sequence wrong");
  chk_ack_token: assert property (
    link_tx_valid |-> link_tx_tok.ctrl &&
    link_tx_tok.data == bls_pkg::END_TOKEN && chan0_alloc)
    else $error("acknowledge is not an END token on channel end 0");
  chk_crc_preset: assert property (
    st_r == bls_pkg::S_DECODE |=> crc_r == bls_pkg::CRC_INIT)
    else $error("checksum not preset at boot start");
endmodule
`default_nettype wire

//--- verilog/bls_buf2.sv
/*
  Two-entry token buffer with valid/ready on both sides.
  Assumes one clock; in_ready and out_valid come straight from flops.
*/
`timescale 1ns/1ns
`default_nettype none
module bls_buf2 (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // filling side
  input wire logic in_valid,
  input wire bls_pkg::bls_tok_t in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output bls_pkg::bls_tok_t out_data,
  input wire logic out_ready
);
  logic v0_r, v1_r;
  bls_pkg::bls_tok_t e1_r;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = !v1_r;
  assign out_valid = v0_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      out_data <= '0;
      e1_r <= '0;
    end else if (pop) begin
      if (v1_r) begin
        out_data <= e1_r;
        if (push) begin
          e1_r <= in_data;
        end else begin
          v1_r <= 1'b0;
        end
      end else begin
        v0_r <= push;
        if (push) begin
          out_data <= in_data;
        end
      end
    end else if (push) begin
      if (!v0_r) begin
        out_data <= in_data;
        v0_r <= 1'b1;
      end else begin
        e1_r <= in_data;
        v1_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/bls_pkg.sv
/*
  Shared constants and types of the boot loader sequencer.
  Assumes a single 10 MHz clock; the reset phase and link enable counts derive from it.
*/
package bls_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int RST_PHASE_US = 15;
  localparam logic [7:0] RST_PHASE_CYC =
    8'((RST_PHASE_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int LINK_EN_NS = 200;
  localparam logic [7:0] LINK_EN_CYC =
    8'((LINK_EN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  // serial clock keeps the same ratio to the core clock as at 400 MHz
  localparam int SPI_CORE_MHZ = 400;
  localparam int SPI_SCLK_KHZ = 2500;
  localparam logic [6:0] SPI_HALF_CYC =
    7'(SPI_CORE_MHZ * 1000 / SPI_SCLK_KHZ / 2);
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_START_ADDR = 24'h000000;
  localparam logic [5:0] SPI_CMD_BITS = 6'h20;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [31:0] NULL_CHAN = 32'h0000FF02;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam int SEC_BOOT_BIT = 5;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam logic [10:0] OTP_BASE = 11'h000;
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_RSVD = 2'h1;
  localparam logic [1:0] SRC_LINK = 2'h2;
  localparam logic [1:0] SRC_SPI = 2'h3;

  typedef struct packed {
    logic [2:0] post_vco_divider;
    logic [11:0] feedback;
    logic [5:0] input_div;
  } bls_pll_t;

  localparam bls_pll_t PLL_R00 = '{3'h1, 12'h07A, 6'h00};
  localparam bls_pll_t PLL_R11 = '{3'h2, 12'h077, 6'h00};
  localparam bls_pll_t PLL_R10 = '{3'h2, 12'h031, 6'h00};
  localparam bls_pll_t PLL_R01 = '{3'h2, 12'h017, 6'h00};

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } bls_tok_t;

  typedef enum logic [3:0] {
    S_RESET = 4'h0, S_DECODE = 4'h1, S_WAIT_TEST = 4'h2,
    S_LINK_EN = 4'h3, S_LINK = 4'h4, S_SPI = 4'h5, S_OTP = 4'h6,
    S_ACK = 4'h7, S_RUN = 4'h8, S_FAIL = 4'h9
  } bls_state_t;

  typedef enum logic [2:0] {
    P_ACK = 3'h0, P_SIZE = 3'h1, P_PROG = 3'h2, P_CRC = 3'h3,
    P_END = 3'h4, P_DONE = 3'h5
  } bls_pstage_t;
endpackage
